// ### ias_map.svh
`ifndef IAS_MAP_SVH
`define IAS_MAP_SVH
// register byte offsets on the wishbone slave
`define IAS_ADR_CTRL 8'h00
`define IAS_ADR_TRIG_SEL 8'h04
`define IAS_ADR_TRIG_CFG 8'h08
`define IAS_ADR_CMD 8'h0C
`define IAS_ADR_EXPOSURE 8'h10
`define IAS_ADR_RATE_LIMIT 8'h14
`define IAS_ADR_EFF_PERIOD 8'h18
`define IAS_ADR_STATUS 8'h1C
// control register fields
`define IAS_CTRL_CONT 0
`define IAS_CTRL_LIMIT_EN 1
`define IAS_CTRL_EXP_MODE 2
// trigger configuration fields (selected trigger only)
`define IAS_TCFG_ON 0
`define IAS_TCFG_SRC 1
// command register bits, write one to execute
`define IAS_CMD_BEGIN 0
`define IAS_CMD_END 1
`define IAS_CMD_SWTRIG 2
// index of the capture-begin trigger in the selector
`define IAS_TSEL_BEGIN 2'h0
// trigger source encoding
`define IAS_SRC_SOFTWARE 1'h0
// reset values
`define IAS_RST_EXPOSURE 32'h0000_0064
`define IAS_RST_RATE_LIMIT 32'h0000_0000
`endif

// ### ias_pkg.sv
package ias_pkg;
	// gray coded along idle, expose, readout, transmit, wait
	typedef enum logic [2:0] {
		IAS_IDLE = 3'h0,
		IAS_EXPOSE = 3'h1,
		IAS_READOUT = 3'h3,
		IAS_TRANSMIT = 3'h2,
		IAS_WAIT = 3'h6
	} ias_state_e;
	typedef logic [31:0] ias_word_t;
endpackage

// ### ias_period_counter.sv
`timescale 1ns/100ps
// down counter pacing free-run frame starts, reloaded at each frame start
module ias_period_counter #(
	parameter int WIDTH = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [WIDTH-1:0] load_val_i,
	output logic done_o
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;

	// a load of zero or one means the period is already spent
	assign cnt_next = load_i ? load_val_i : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
	assign done_o = (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1});

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ### ias_sequencer.sv
// What this block does
// - with capture-begin trigger off, frames start from settings alone, no trigger needed
// - a selector picks the trigger; on/off and source apply to that trigger only
// - single frame untriggered: begin command exposes, reads out, transmits one image
// - continuous untriggered: begin starts, frames repeat alone, end command stops
// - limit enabled and slower than maximum: frames paced by the limit setting
// - limit disabled or faster than maximum: frames paced at the maximum rate
// - software trigger starts capture with exposure from the exposure setting
// - with triggering on, begin command arms; triggers before arming are ignored
// - after exposure ends the image is read out and then transmitted
// - single frame triggered: further triggers ignored until armed again
// - continuous triggered: stays armed, one frame per trigger, end command disarms
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "ias_map.svh"
module ias_sequencer #(
	parameter int NTRIG = 4,
	parameter int PW = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [PW-1:0] min_period_i,
	output logic exposure_o,
	output logic readout_start_o,
	input wire logic readout_done_i,
	output logic transmit_start_o,
	input wire logic transmit_done_i
);
	ias_pkg::ias_state_e state_reg;
	ias_pkg::ias_state_e state_next;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic cont_reg;
	logic limit_en_reg;
	logic exp_mode_reg;
	logic [1:0] tsel_reg;
	logic [NTRIG-1:0] trig_on_reg;
	logic [NTRIG-1:0] trig_src_reg;
	logic [31:0] exposure_reg;
	logic [PW-1:0] limit_reg;
	logic [31:0] exp_cnt_reg;
	logic active_reg;
	logic armed_reg;
	logic rdo_pulse_reg;
	logic tx_pulse_reg;
	logic [PW-1:0] gap_reg;
	logic [PW-1:0] gap_goal_reg;

	// wishbone decode; one cycle wait state, unmapped reads return zero
	wire req = cyc_i & stb_i & ~ack_reg;
	wire wr = req & we_i & sel_i[0];
	wire hit_ctrl = adr_i == `IAS_ADR_CTRL;
	wire hit_tsel = adr_i == `IAS_ADR_TRIG_SEL;
	wire hit_tcfg = adr_i == `IAS_ADR_TRIG_CFG;
	wire hit_cmd = adr_i == `IAS_ADR_CMD;
	wire hit_exp = adr_i == `IAS_ADR_EXPOSURE;
	wire hit_lim = adr_i == `IAS_ADR_RATE_LIMIT;
	wire hit_eff = adr_i == `IAS_ADR_EFF_PERIOD;
	wire hit_stat = adr_i == `IAS_ADR_STATUS;

	// commands are one-cycle strobes on the write edge
	wire cmd_begin = wr & hit_cmd & dat_i[`IAS_CMD_BEGIN];
	wire cmd_end = wr & hit_cmd & dat_i[`IAS_CMD_END];
	wire cmd_swtrig = wr & hit_cmd & dat_i[`IAS_CMD_SWTRIG];

	// only the capture-begin trigger steers this sequencer
	wire trig_on = trig_on_reg[`IAS_TSEL_BEGIN];
	wire sw_src = trig_src_reg[`IAS_TSEL_BEGIN] == `IAS_SRC_SOFTWARE;
	wire sw_mode = trig_on & sw_src;

	// effective period: the limit only counts when enabled and slower than maximum
	wire use_limit = limit_en_reg & (limit_reg > min_period_i);
	wire [PW-1:0] eff_period = use_limit ? limit_reg : min_period_i;

	wire period_done;
	wire idle = state_reg == ias_pkg::IAS_IDLE;
	wire in_wait = state_reg == ias_pkg::IAS_WAIT;
	// untriggered: begin starts the first frame, the counter the later ones
	wire free_start = ~trig_on & ((idle & cmd_begin) | (in_wait & active_reg & period_done));
	// triggered: trigger honoured only when armed and idle
	wire trig_start = sw_mode & armed_reg & idle & cmd_swtrig;
	wire frame_start = free_start | trig_start;
	wire exp_last = exp_cnt_reg <= 32'h0000_0001;
	wire tx_end = (state_reg == ias_pkg::IAS_TRANSMIT) & transmit_done_i;

	ias_period_counter #(
		.WIDTH(PW)
	) u_period (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(frame_start),
		.load_val_i(eff_period),
		.done_o(period_done)
	);

	// frame sequence; end command lets the frame in flight finish
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ias_pkg::IAS_IDLE: begin
				if (frame_start) begin
					state_next = ias_pkg::IAS_EXPOSE;
				end
			end
			ias_pkg::IAS_EXPOSE: begin
				if (exp_last) begin
					state_next = ias_pkg::IAS_READOUT;
				end
			end
			ias_pkg::IAS_READOUT: begin
				if (readout_done_i) begin
					state_next = ias_pkg::IAS_TRANSMIT;
				end
			end
			ias_pkg::IAS_TRANSMIT: begin
				if (transmit_done_i) begin
					// only untriggered continuous capture paces itself
					if (cont_reg & ~trig_on & active_reg) begin
						state_next = ias_pkg::IAS_WAIT;
					end else begin
						state_next = ias_pkg::IAS_IDLE;
					end
				end
			end
			ias_pkg::IAS_WAIT: begin
				if (free_start) begin
					state_next = ias_pkg::IAS_EXPOSE;
				end else if (~active_reg) begin
					state_next = ias_pkg::IAS_IDLE;
				end
			end
			default: begin
				state_next = ias_pkg::IAS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ias_pkg::IAS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// exposure length counted in clock cycles, loaded at frame start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exp_cnt_reg <= 32'h0000_0000;
		end else if (frame_start) begin
			exp_cnt_reg <= exposure_reg;
		end else if (state_reg == ias_pkg::IAS_EXPOSE && !exp_last) begin
			exp_cnt_reg <= exp_cnt_reg - 32'h0000_0001;
		end
	end

	// acquisition active and armed flags; begin wins over end when both are written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else if (cmd_begin) begin
			active_reg <= ~trig_on & cont_reg;
			armed_reg <= trig_on;
		end else if (cmd_end) begin
			active_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else if (trig_start & ~cont_reg) begin
			armed_reg <= 1'b0;
		end
	end

	// handshake strobes towards readout and transmission
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdo_pulse_reg <= 1'b0;
			tx_pulse_reg <= 1'b0;
		end else begin
			rdo_pulse_reg <= (state_reg == ias_pkg::IAS_EXPOSE) & exp_last;
			tx_pulse_reg <= (state_reg == ias_pkg::IAS_READOUT) & readout_done_i;
		end
	end

	assign exposure_o = state_reg == ias_pkg::IAS_EXPOSE;
	assign readout_start_o = rdo_pulse_reg;
	assign transmit_start_o = tx_pulse_reg;

	// plain settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cont_reg <= 1'b0;
			limit_en_reg <= 1'b0;
			exp_mode_reg <= 1'b0;
			tsel_reg <= `IAS_TSEL_BEGIN;
			exposure_reg <= `IAS_RST_EXPOSURE;
			limit_reg <= PW'(`IAS_RST_RATE_LIMIT);
		end else if (wr) begin
			if (hit_ctrl) begin
				cont_reg <= dat_i[`IAS_CTRL_CONT];
				limit_en_reg <= dat_i[`IAS_CTRL_LIMIT_EN];
				exp_mode_reg <= dat_i[`IAS_CTRL_EXP_MODE];
			end
			if (hit_tsel) begin
				tsel_reg <= dat_i[1:0];
			end
			if (hit_exp) begin
				exposure_reg <= dat_i;
			end
			if (hit_lim) begin
				limit_reg <= dat_i[PW-1:0];
			end
		end
	end

	// one on/off and source pair per trigger, written through the selector
	genvar gi;
	generate
		for (gi = 0; gi < NTRIG; gi++) begin : g_trig
			wire tcfg_wr = wr & hit_tcfg & (tsel_reg == 2'(gi));
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					trig_on_reg[gi] <= 1'b0;
					trig_src_reg[gi] <= `IAS_SRC_SOFTWARE;
				end else if (tcfg_wr) begin
					trig_on_reg[gi] <= dat_i[`IAS_TCFG_ON];
					trig_src_reg[gi] <= dat_i[`IAS_TCFG_SRC];
				end
			end
		end
	endgenerate

	// read mux; command register reads as zero
	wire [31:0] rd_ctrl = {29'h0, exp_mode_reg, limit_en_reg, cont_reg};
	wire [31:0] rd_tcfg = {30'h0, trig_src_reg[tsel_reg], trig_on_reg[tsel_reg]};
	wire [31:0] rd_stat = {26'h0, armed_reg, active_reg, period_done, state_reg};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_tsel ? {30'h0, tsel_reg} :
		hit_tcfg ? rd_tcfg :
		hit_exp ? exposure_reg :
		hit_lim ? 32'(limit_reg) :
		hit_eff ? 32'(eff_period) :
		hit_stat ? rd_stat : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			rdat_reg <= rd_mux;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = rdat_reg;

	// cycles since the last frame start and the period loaded then; feeds the pacing check only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap_reg <= '0;
			gap_goal_reg <= '0;
		end else if (frame_start) begin
			gap_reg <= '0;
			gap_goal_reg <= eff_period;
		end else if (gap_reg != '1) begin
			gap_reg <= gap_reg + 1'b1; // saturates so a long stop cannot wrap it
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	free_start_a: assert property (idle & ~trig_on & cmd_begin |=> exposure_o)
		else $error("untriggered begin did not start exposure");
	trig_index_a: assert property (wr & hit_tcfg |=> trig_on_reg[$past(tsel_reg)] == $past(dat_i[0]))
		else $error("trigger config missed selected entry");
	single_once_a: assert property (tx_end & ~cont_reg |=> idle ##1 (idle | exposure_o))
		else $error("single frame did not return to idle");
	expose_ends_a: assert property ($rose(exposure_o) ##0 (exposure_reg > 32'h1) |=> exposure_o)
		else $error("exposure ended too early");
	readout_next_a: assert property ($fell(exposure_o) |-> readout_start_o ##0 state_reg == ias_pkg::IAS_READOUT)
		else $error("readout did not follow exposure");
	cont_pace_a: assert property (tx_end & cont_reg & ~trig_on & active_reg |=> in_wait)
		else $error("free-run did not pace next frame");
	end_stops_a: assert property (cmd_end & ~cmd_begin |=> ~active_reg & ~armed_reg)
		else $error("end command did not stop capture");
	rate_pick_a: assert property (!limit_en_reg |-> eff_period == min_period_i)
		else $error("disabled limit changed the period");
	rate_floor_a: assert property (in_wait & free_start |-> gap_reg + PW'(1) >= gap_goal_reg)
		else $error("free-run frame started before its period ran out");
	arm_needed_a: assert property (idle & trig_on & ~armed_reg & ~cmd_begin |=> ~exposure_o)
		else $error("trigger acted on before arming");
	single_disarm_a: assert property (trig_start & ~cont_reg & ~cmd_begin |=> ~armed_reg)
		else $error("single triggered frame left armed");
	cont_armed_a: assert property (trig_start & cont_reg & ~cmd_end |=> armed_reg)
		else $error("continuous triggered frame dropped the arming");
	reload_a: assert property (frame_start & (eff_period > PW'(2)) |=> ~period_done)
		else $error("period counter not reloaded");

	single_c: cover property (idle & cmd_begin & ~trig_on & ~cont_reg);
	freerun_c: cover property (in_wait & free_start);
	swtrig_c: cover property (trig_start & cont_reg);
	single_trig_c: cover property (trig_start & ~cont_reg);
	limit_pace_c: cover property (in_wait & free_start & use_limit);
endmodule

// ### testbench.sv
`timescale 1ns/100ps
`include "ias_map.svh"
module testbench;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, readout_done_i, transmit_done_i;
	logic exposure_o, readout_start_o, transmit_start_o, exp_d;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, min_period_i, q;
	int fail_count, n_compared, cyc_no, frames, t_last, t_prev, exp_len, rd_cnt, tx_cnt, f, p20, p60;

	ias_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.min_period_i(min_period_i), .exposure_o(exposure_o), .readout_start_o(readout_start_o),
		.readout_done_i(readout_done_i), .transmit_start_o(transmit_start_o),
		.transmit_done_i(transmit_done_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// frame monitor; readout and transmit answer one cycle after their start strobe
	always @(posedge clk_i) begin
		cyc_no++;
		if (exposure_o === 1'b1 && exp_d !== 1'b1) begin
			frames++;
			t_prev = t_last;
			t_last = cyc_no;
			exp_len = 0;
		end
		if (exposure_o === 1'b1) exp_len++;
		exp_d = exposure_o;
		if (readout_start_o === 1'b1) rd_cnt++;
		if (transmit_start_o === 1'b1) tx_cnt++;
		readout_done_i <= readout_start_o;
		transmit_done_i <= transmit_start_o;
	end

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	// one classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic acked;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		acked = (ack_o === 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
		if (!acked) begin
			$display("MISMATCH at %0t: bus timeout", $time);
			fail_count++;
			tally_and_finish();
		end
	endtask

	// bounded wait until the frame count reaches n
	task automatic wait_frames(input int n);
		int k;
		for (k = 0; k < 2000 && frames < n; k++) @(posedge clk_i);
		repeat (20) @(posedge clk_i);
		if (frames < n) begin
			$display("MISMATCH at %0t: frame timeout", $time);
			fail_count++;
			tally_and_finish();
		end
	endtask

	initial begin
		{rst_i, cyc_i, stb_i, we_i, readout_done_i, transmit_done_i} = 6'h20;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0;
		min_period_i = 32'h14;
		{fail_count, n_compared, cyc_no, frames, t_last, t_prev, exp_len, rd_cnt, tx_cnt} = '0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset values, write-only command and unmapped place
		wb(0, `IAS_ADR_EXPOSURE, 0); chk(q, `IAS_RST_EXPOSURE);
		wb(0, `IAS_ADR_RATE_LIMIT, 0); chk(q, `IAS_RST_RATE_LIMIT);
		wb(0, `IAS_ADR_CMD, 0); chk(q, 32'h0);
		wb(0, 8'h20, 0); chk(q, 32'h0);
		// untriggered single frame with a short exposure
		wb(1, `IAS_ADR_EXPOSURE, 32'h3);
		wb(1, `IAS_ADR_CMD, 32'h1);
		wait_frames(1);
		repeat (30) @(posedge clk_i);
		chk(frames, 1);
		chk(exp_len, 3);
		chk(tx_cnt, 1);
		// software trigger, single frame; trigger 1 off must not touch trigger 0
		wb(1, `IAS_ADR_TRIG_CFG, 32'h1);
		wb(1, `IAS_ADR_TRIG_SEL, 32'h1);
		wb(1, `IAS_ADR_TRIG_CFG, 32'h0);
		wb(1, `IAS_ADR_TRIG_SEL, 32'h0);
		wb(0, `IAS_ADR_TRIG_CFG, 0); chk(q, 32'h1);
		wb(1, `IAS_ADR_CTRL, 32'h4);
		wb(1, `IAS_ADR_CMD, 32'h4);
		repeat (30) @(posedge clk_i);
		chk(frames, 1);
		wb(1, `IAS_ADR_CMD, 32'h1);
		repeat (30) @(posedge clk_i);
		chk(frames, 1);
		wb(1, `IAS_ADR_CMD, 32'h4);
		wait_frames(2);
		chk(exp_len, 3);
		wb(1, `IAS_ADR_CMD, 32'h4);
		repeat (30) @(posedge clk_i);
		chk(frames, 2);
		// software trigger, continuous: one frame per trigger until end
		wb(1, `IAS_ADR_CTRL, 32'h5);
		wb(1, `IAS_ADR_CMD, 32'h1);
		wb(0, `IAS_ADR_STATUS, 0); chk(q, 32'h28);
		wb(1, `IAS_ADR_CMD, 32'h4);
		wait_frames(3);
		wb(1, `IAS_ADR_CMD, 32'h4);
		wait_frames(4);
		chk(frames, 4);
		wb(1, `IAS_ADR_CMD, 32'h2);
		wb(1, `IAS_ADR_CMD, 32'h4);
		repeat (30) @(posedge clk_i);
		chk(frames, 4);
		wb(0, `IAS_ADR_STATUS, 0); chk(q, 32'h8);
		// free run: limited period, then maximum rate twice
		wb(1, `IAS_ADR_TRIG_CFG, 32'h0);
		wb(1, `IAS_ADR_RATE_LIMIT, 32'h3C);
		wb(1, `IAS_ADR_CTRL, 32'h3);
		wb(0, `IAS_ADR_EFF_PERIOD, 0); chk(q, 32'h3C);
		wb(1, `IAS_ADR_CMD, 32'h1);
		wait_frames(7);
		p60 = t_last - t_prev;
		wb(1, `IAS_ADR_CTRL, 32'h1);
		wb(0, `IAS_ADR_EFF_PERIOD, 0); chk(q, 32'h14);
		wait_frames(frames + 3);
		p20 = t_last - t_prev;
		chk(p60 - p20, 40);
		chk(p20 >= 20 && p20 <= 22, 1);
		wb(1, `IAS_ADR_RATE_LIMIT, 32'hA);
		wb(1, `IAS_ADR_CTRL, 32'h3);
		wb(0, `IAS_ADR_EFF_PERIOD, 0); chk(q, 32'h14);
		wait_frames(frames + 3);
		chk(t_last - t_prev, p20);
		wb(1, `IAS_ADR_CMD, 32'h2);
		repeat (30) @(posedge clk_i);
		f = frames;
		repeat (100) @(posedge clk_i);
		chk(frames, f);
		wb(0, `IAS_ADR_STATUS, 0); chk(q, 32'h8);
		chk(rd_cnt, frames);
		chk(tx_cnt, frames);
		tally_and_finish();
	end
endmodule
